// ==== rtl/gpio_bank_with_edge_interrupt.sv ====
`timescale 1ns/1ps
module gpio_bank_with_edge_interrupt
  import gpio_bank_pkg::*;
#(
  parameter int PIN_COUNT = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // register port
  input wire gpio_bank_pkg::reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  // pins
  input wire logic [PIN_COUNT-1:0] pin_in,
  output logic [PIN_COUNT-1:0] pin_out,
  output logic [PIN_COUNT-1:0] pin_oe_out,
  // pad configuration
  output gpio_bank_pkg::pad_cfg_t pad_cfg_out,
  // interrupt
  output logic irq_out_low
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (PIN_COUNT != 8)
  begin : g_bad_width
    $error("gpio bank supports exactly eight pins");
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] input_buffer_disable_reg;
  logic [7:0] output_slew_select_reg;
  logic [7:0] output_drive_reduce_reg;
  logic [7:0] pull_up_enable_reg;
  logic [7:0] pull_down_enable_reg;
  logic [7:0] open_drain_enable_reg;
  logic [7:0] polarity_invert_reg;
  logic [7:0] pin_direction_reg;
  logic [7:0] pin_data_reg;
  logic [7:0] irq_pin_mask_reg;
  logic [7:0] edge_select_upper_reg;
  logic [7:0] edge_select_lower_reg;
  logic [7:0] irq_pending_flags_reg;
  logic [7:0] irq_pending_flags_next;
  logic [7:0] edge_event_flags_reg;
  logic [7:0] edge_event_flags_next;
  logic [7:0] misc_settings_reg;
  logic [7:0] prev_view_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] pin_out_reg;
  logic [7:0] pin_out_next;
  logic [7:0] pin_oe_reg;
  logic [7:0] pin_oe_next;
  pad_cfg_t pad_cfg_reg;
  pad_cfg_t pad_cfg_next;
  logic irq_low_reg;
  logic irq_low_next;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire wr_en = reg_req_in.wr;
  wire rd_en = reg_req_in.rd;
  wire [7:0] addr = reg_req_in.addr;
  wire [7:0] wdata = reg_req_in.wdata;
  wire wr_pending = wr_en && (addr == ADDR_IRQ_PENDING);
  wire wr_event = wr_en && (addr == ADDR_EVENT_STATUS);
  wire rd_data = rd_en && (addr == ADDR_DATA);
  wire autoclear_on = ~misc_settings_reg[MISC_AUTOCLEAR_OFF_BIT];
  wire rd_clear = rd_data && autoclear_on;

  // ----------------------------------------------------------------
  // pin input path
  // ----------------------------------------------------------------
  wire [7:0] pin_sync;
  wire [7:0] pin_seen = pin_sync & ~input_buffer_disable_reg;
  wire [7:0] data_view = pin_seen ^ polarity_invert_reg;

  gpio_pin_sync #(
    .WIDTH(PIN_COUNT)
  ) u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .level_in(pin_in),
    .level_out(pin_sync)
  );

  // ----------------------------------------------------------------
  // edge detection per pin
  // ----------------------------------------------------------------
  wire [15:0] sense_all = {edge_select_upper_reg, edge_select_lower_reg};
  wire [7:0] rise = data_view & ~prev_view_reg;
  wire [7:0] fall = ~data_view & prev_view_reg;
  logic [7:0] edge_hit;

  for (genvar i = 0; i < PIN_COUNT; i++)
  begin : g_edge
    wire sense_t sel = sense_t'(sense_all[SENSE_WIDTH*i +: SENSE_WIDTH]);
    assign edge_hit[i] = ((sel == SENSE_RISING) && rise[i]) ||
                         ((sel == SENSE_FALLING) && fall[i]) ||
                         ((sel == SENSE_BOTH) && (rise[i] || fall[i]));
  end

  // unmasked input pins only
  wire [7:0] pend_set = edge_hit & ~irq_pin_mask_reg & pin_direction_reg;

  // set wins over any clear
  assign irq_pending_flags_next = pend_set |
    (rd_clear ? RESET_ZERO :
     irq_pending_flags_reg & ~(wr_pending ? wdata : RESET_ZERO) &
     ~(wr_event ? wdata : RESET_ZERO));
  assign edge_event_flags_next = edge_hit |
    (edge_event_flags_reg & ~(wr_event ? wdata : RESET_ZERO));
  assign irq_low_next = (irq_pending_flags_next == RESET_ZERO);

  // ----------------------------------------------------------------
  // pin output path
  // ----------------------------------------------------------------
  wire [7:0] drive_level = pin_data_reg ^ polarity_invert_reg;
  wire [7:0] is_output = ~pin_direction_reg;
  // open drain only ever pulls low
  assign pin_out_next = drive_level & ~open_drain_enable_reg;
  assign pin_oe_next = is_output &
    (~open_drain_enable_reg | ~drive_level);

  assign pad_cfg_next.input_off = input_buffer_disable_reg;
  assign pad_cfg_next.fast_slew = output_slew_select_reg & is_output;
  assign pad_cfg_next.low_drive = output_drive_reduce_reg & is_output;
  assign pad_cfg_next.pull_up = pull_up_enable_reg;
  assign pad_cfg_next.pull_down = pull_down_enable_reg;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  assign rdata_next = !rd_en ? rdata_reg :
    (addr == ADDR_INPUT_DISABLE) ? input_buffer_disable_reg :
    (addr == ADDR_SLEW) ? output_slew_select_reg :
    (addr == ADDR_DRIVE) ? output_drive_reduce_reg :
    (addr == ADDR_PULL_UP) ? pull_up_enable_reg :
    (addr == ADDR_PULL_DOWN) ? pull_down_enable_reg :
    (addr == ADDR_OPEN_DRAIN) ? open_drain_enable_reg :
    (addr == ADDR_POLARITY) ? polarity_invert_reg :
    (addr == ADDR_DIRECTION) ? pin_direction_reg :
    (addr == ADDR_DATA) ? data_view :
    (addr == ADDR_IRQ_MASK) ? irq_pin_mask_reg :
    (addr == ADDR_SENSE_UPPER) ? edge_select_upper_reg :
    (addr == ADDR_SENSE_LOWER) ? edge_select_lower_reg :
    (addr == ADDR_IRQ_PENDING) ? irq_pending_flags_reg :
    (addr == ADDR_EVENT_STATUS) ? edge_event_flags_reg :
    (addr == ADDR_MISC) ? misc_settings_reg : RESET_ZERO;

  // ----------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      input_buffer_disable_reg <= RESET_ZERO;
      output_slew_select_reg <= RESET_ZERO;
      output_drive_reduce_reg <= RESET_ZERO;
      pull_up_enable_reg <= RESET_ZERO;
      pull_down_enable_reg <= RESET_ZERO;
      open_drain_enable_reg <= RESET_ZERO;
      polarity_invert_reg <= RESET_ZERO;
      pin_direction_reg <= RESET_ONES;
      pin_data_reg <= RESET_ONES;
      irq_pin_mask_reg <= RESET_ONES;
      edge_select_upper_reg <= RESET_ZERO;
      edge_select_lower_reg <= RESET_ZERO;
      misc_settings_reg <= RESET_ZERO;
    end
    else if (wr_en)
    begin
      case (addr)
        ADDR_INPUT_DISABLE: input_buffer_disable_reg <= wdata;
        ADDR_SLEW: output_slew_select_reg <= wdata;
        ADDR_DRIVE: output_drive_reduce_reg <= wdata;
        ADDR_PULL_UP: pull_up_enable_reg <= wdata;
        ADDR_PULL_DOWN: pull_down_enable_reg <= wdata;
        ADDR_OPEN_DRAIN: open_drain_enable_reg <= wdata;
        ADDR_POLARITY: polarity_invert_reg <= wdata;
        ADDR_DIRECTION: pin_direction_reg <= wdata;
        ADDR_DATA: pin_data_reg <= wdata;
        ADDR_IRQ_MASK: irq_pin_mask_reg <= wdata;
        ADDR_SENSE_UPPER: edge_select_upper_reg <= wdata;
        ADDR_SENSE_LOWER: edge_select_lower_reg <= wdata;
        ADDR_MISC: misc_settings_reg <= wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status and output flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      irq_pending_flags_reg <= RESET_ZERO;
      edge_event_flags_reg <= RESET_ZERO;
      prev_view_reg <= RESET_ZERO;
      rdata_reg <= RESET_ZERO;
      pin_out_reg <= RESET_ZERO;
      pin_oe_reg <= RESET_ZERO;
      pad_cfg_reg <= '0;
      irq_low_reg <= 1'b1;
    end
    else
    begin
      irq_pending_flags_reg <= irq_pending_flags_next;
      edge_event_flags_reg <= edge_event_flags_next;
      prev_view_reg <= data_view;
      rdata_reg <= rdata_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
      pad_cfg_reg <= pad_cfg_next;
      irq_low_reg <= irq_low_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe_out = pin_oe_reg;
  assign pad_cfg_out = pad_cfg_reg;
  assign irq_out_low = irq_low_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  input_off_view_a: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) input_buffer_disable_reg[0] |->
    data_view[0] == polarity_invert_reg[0])
    else $error("disabled input buffer leaks pin level");

  slew_out_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    pin_direction_reg[0] |=> !pad_cfg_out.fast_slew[0])
    else $error("fast slew shown on input pin");

  open_drain_a: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) (open_drain_enable_reg[0] && !pin_direction_reg[0]) |=>
    (!pin_out[0] && pin_oe_out[0] == $past(!drive_level[0])))
    else $error("open drain pin drives high");

  push_pull_a: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) (!open_drain_enable_reg[0] && !pin_direction_reg[0]) |=>
    (pin_oe_out[0] && pin_out[0] == $past(drive_level[0])))
    else $error("push pull output wrong level");

  input_float_a: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) pin_direction_reg[0] |=> !pin_oe_out[0])
    else $error("input pin is driven");

  data_read_a: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) rd_data |=> reg_rdata_out == $past(data_view))
    else $error("data read not pin view");

  mask_block_a: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) (irq_pin_mask_reg == RESET_ONES) |->
    pend_set == RESET_ZERO)
    else $error("masked pin raised pending");

  pend_set_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (pend_set != RESET_ZERO) |=> (!irq_out_low &&
    (irq_pending_flags_reg & $past(pend_set)) == $past(pend_set)))
    else $error("edge did not raise pending");

  w1c_clear_a: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) (wr_pending && wdata == RESET_ONES &&
    pend_set == RESET_ZERO) |=> irq_pending_flags_reg == RESET_ZERO)
    else $error("write one did not clear pending");

  irq_release_a: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) irq_out_low == (irq_pending_flags_reg == RESET_ZERO))
    else $error("irq level disagrees with pending");

  event_set_a: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) (edge_hit != RESET_ZERO) |=>
    (edge_event_flags_reg & $past(edge_hit)) == $past(edge_hit))
    else $error("edge not recorded in event flags");

  auto_clear_a: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) (rd_data && autoclear_on && pend_set == RESET_ZERO) |=>
    irq_pending_flags_reg == RESET_ZERO)
    else $error("data read did not clear pending");

endmodule

// ==== pkg/gpio_bank_pkg.sv ====
// Operation
// - input-disable bit 1 turns input buffer off
// - slew bit 1 selects faster output edges
// - drive bit 1 halves output drive
// - pull-up bit 1 enables the pull-up
// - pull-down bit 1 enables the pull-down
// - open-drain bit 1 drives only low
// - polarity bit 1 inverts data versus pin
// - direction 0 output, 1 input, resets ones
// - data write sets output levels, resets ones
// - data read returns pin levels after inversion
// - mask bit 1 stops an input pin from interrupting, resets ones
// - two-bit sense field per pin, two registers
// - sense codes none, rising, falling, both
// - unmasked edge on an input pin sets pending bit, irq low
// - pending bits clear on write one
// - irq releases high once pending is empty
// - edge sets event bit; write one clears both
// - data read clears pending unless auto-clear off
package gpio_bank_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INPUT_DISABLE = 8'h00;
  localparam logic [7:0] ADDR_SLEW = 8'h01;
  localparam logic [7:0] ADDR_DRIVE = 8'h02;
  localparam logic [7:0] ADDR_PULL_UP = 8'h03;
  localparam logic [7:0] ADDR_PULL_DOWN = 8'h04;
  localparam logic [7:0] ADDR_OPEN_DRAIN = 8'h05;
  localparam logic [7:0] ADDR_POLARITY = 8'h06;
  localparam logic [7:0] ADDR_DIRECTION = 8'h07;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h09;
  localparam logic [7:0] ADDR_SENSE_UPPER = 8'h0A;
  localparam logic [7:0] ADDR_SENSE_LOWER = 8'h0B;
  localparam logic [7:0] ADDR_IRQ_PENDING = 8'h0C;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h0D;
  localparam logic [7:0] ADDR_MISC = 8'h10;

  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_ONES = 8'hFF;
  localparam int MISC_AUTOCLEAR_OFF_BIT = 0;
  localparam int SENSE_WIDTH = 2;

  typedef enum logic [1:0] {
    SENSE_NONE = 2'b00,
    SENSE_RISING = 2'b01,
    SENSE_FALLING = 2'b10,
    SENSE_BOTH = 2'b11
  } sense_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] input_off;
    logic [7:0] fast_slew;
    logic [7:0] low_drive;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
  } pad_cfg_t;

endpackage

// ==== rtl/gpio_pin_sync.sv ====
`timescale 1ns/1ps
module gpio_pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // levels
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // ----------------------------------------------------------------
  // two-flop synchroniser per bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= level_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign level_out = stage2_reg;
endmodule

// ==== verification/gpio_pin_partner.sv ====
`timescale 1ns/1ps
module gpio_pin_partner
  import gpio_bank_pkg::*;
(
  // device side
  input wire logic clk_sys_in,
  input wire logic [7:0] pin_out_in,
  input wire logic [7:0] pin_oe_in,
  input wire gpio_bank_pkg::pad_cfg_t pad_cfg_in,
  // outside drive
  input wire logic [7:0] ext_val_in,
  input wire logic [7:0] ext_en_in,
  // resolved line levels
  output logic [7:0] level_out
);
  logic [7:0] float_reg = 8'h00;

  // a line nobody drives or pulls wanders every cycle
  always_ff @(posedge clk_sys_in)
    float_reg <= ~float_reg;

  // device drive wins, then outside drive, then the pulls
  always_comb
    for (int i = 0; i < 8; i++)
      if (pin_oe_in[i])
        level_out[i] = pin_out_in[i];
      else if (ext_en_in[i])
        level_out[i] = ext_val_in[i];
      else if (pad_cfg_in.pull_up[i])
        level_out[i] = 1'b1;
      else if (pad_cfg_in.pull_down[i])
        level_out[i] = 1'b0;
      else
        level_out[i] = float_reg[i];
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
  import gpio_bank_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  reg_req_t req = '0;
  logic [7:0] rdata, lvl, pin_o, pin_oe;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] ext_en = 8'hFF;
  pad_cfg_t pad;
  logic irq_low;
  int num_errors = 0;
  int n_checks = 0;
  logic [7:0] v, od, pol, dat, dis, got, ex;
  logic [7:0] wv [12];

  always #5 clk_sys = ~clk_sys;

  gpio_bank_with_edge_interrupt #(.PIN_COUNT(8))
    gpio_bank_with_edge_interrupt_i (.clk_sys_in(clk_sys),
    .reset_in(reset), .reg_req_in(req), .reg_rdata_out(rdata),
    .pin_in(lvl), .pin_out(pin_o), .pin_oe_out(pin_oe),
    .pad_cfg_out(pad), .irq_out_low(irq_low));

  gpio_pin_partner gpio_pin_partner_i (.clk_sys_in(clk_sys),
    .pin_out_in(pin_o), .pin_oe_in(pin_oe), .pad_cfg_in(pad),
    .ext_val_in(ext_val), .ext_en_in(ext_en), .level_out(lvl));

  // ----------------------------------------------------------------
  // bus tasks and compares
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    req <= '0;
    #1 d = rdata;
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    chk_byte({7'h00, g}, {7'h00, e});
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // expectations
  // ----------------------------------------------------------------
  function automatic logic [7:0] reset_val(input int a);
    return (a == 7 || a == 9) ? 8'hFF : 8'h00;
  endfunction

  function automatic logic [7:0] exp_oe(input logic [7:0] o, p, d);
    return ~o | ~(d ^ p);
  endfunction

  function automatic logic [7:0] exp_view(input logic [7:0] s, p, x);
    return (s & ~x) ^ p;
  endfunction

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(25));
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    for (int a = 0; a <= 16; a++)
      if (a != 8 && (a < 14 || a == 16))
      begin
        rd(a[7:0], got);
        chk_byte(got, reset_val(a));
      end
    chk_byte(pin_oe, 8'h00);
    chk_bit(irq_low, 1'b1);
    $display("test reset done");

    for (int a = 0; a <= 11; a++)
      if (a != 8)
      begin
        v = 8'($urandom);
        wv[a] = v;
        wr(a[7:0], v);
        rd(a[7:0], got);
        chk_byte(got, v);
        if (a < 5)
        begin
          // slew and drive only show on output pins, all inputs here
          ex = (a == 1 || a == 2) ? 8'h00 : v;
          chk_byte(pad[39-8*a -: 8], ex);
        end
      end
    chk_byte(pad.fast_slew, wv[1] & ~wv[7]);
    chk_byte(pad.low_drive, wv[2] & ~wv[7]);
    wr(8'h20, 8'hFF);
    rd(8'h20, got);
    chk_byte(got, 8'h00);
    $display("test registers done");

    wr(ADDR_PULL_UP, 8'hFF);
    wr(ADDR_PULL_DOWN, 8'h00);
    wr(ADDR_DIRECTION, 8'h00);
    // outside drive off so released open-drain lines reach the pull-up
    ext_en <= 8'h00;
    for (int n = 0; n < 20; n++)
    begin
      {dis, pol, od, dat} = $urandom;
      if (n == 0)
        {dis, pol, od, dat} = {8'h00, 8'h00, 8'h00, 8'h00};
      wr(ADDR_INPUT_DISABLE, dis);
      wr(ADDR_OPEN_DRAIN, od);
      wr(ADDR_POLARITY, pol);
      wr(ADDR_DATA, dat);
      repeat (4) @(posedge clk_sys);
      #1 ex = exp_oe(od, pol, dat);
      chk_byte(pin_oe, ex);
      chk_byte(pin_o & ex, (dat ^ pol) & ~od & ex);
      rd(ADDR_DATA, got);
      chk_byte(got, exp_view(dat ^ pol, pol, dis));
    end
    $display("test outputs done");

    wr(ADDR_INPUT_DISABLE, 8'h00);
    ext_en <= 8'hFF;
    wr(ADDR_POLARITY, 8'h00);
    wr(ADDR_DIRECTION, 8'hFF);
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_MISC, 8'h01);
    wr(ADDR_IRQ_PENDING, 8'hFF);
    wr(ADDR_EVENT_STATUS, 8'hFF);
    for (int i = 0; i < 8; i++)
      for (int c = 0; c < 4; c++)
      begin
        v = 8'(c << (2 * (i % 4)));
        wr(ADDR_SENSE_UPPER, (i > 3) ? v : 8'h00);
        wr(ADDR_SENSE_LOWER, (i > 3) ? 8'h00 : v);
        for (int e = 0; e < 2; e++)
        begin
          @(posedge clk_sys);
          ext_val <= (e == 0) ? 8'(1 << i) : 8'h00;
          repeat (5) @(posedge clk_sys);
          ex = c[e] ? 8'(1 << i) : 8'h00;
          rd(ADDR_IRQ_PENDING, got);
          chk_byte(got, ex);
          chk_bit(irq_low, ex == 8'h00);
          wr(ADDR_IRQ_PENDING, 8'hFF);
          wr(ADDR_EVENT_STATUS, 8'hFF);
          chk_bit(irq_low, 1'b1);
        end
      end
    $display("test edges done");

    wr(ADDR_SENSE_UPPER, 8'h00);
    wr(ADDR_SENSE_LOWER, 8'h03);
    wr(ADDR_IRQ_MASK, 8'hFF);
    ext_val <= 8'h01;
    repeat (5) @(posedge clk_sys);
    rd(ADDR_IRQ_PENDING, got);
    chk_byte(got, 8'h00);
    rd(ADDR_EVENT_STATUS, got);
    chk_byte(got, 8'h01);
    wr(ADDR_EVENT_STATUS, 8'hFF);
    wr(ADDR_IRQ_MASK, 8'hFE);
    ext_val <= 8'h00;
    repeat (5) @(posedge clk_sys);
    wr(ADDR_IRQ_PENDING, 8'h00);
    rd(ADDR_IRQ_PENDING, got);
    chk_byte(got, 8'h01);
    chk_bit(irq_low, 1'b0);
    wr(ADDR_EVENT_STATUS, 8'h01);
    rd(ADDR_IRQ_PENDING, got);
    chk_byte(got, 8'h00);
    chk_bit(irq_low, 1'b1);
    @(posedge clk_sys);
    ext_val <= 8'h01;
    repeat (5) @(posedge clk_sys);
    rd(ADDR_DATA, got);
    chk_byte(got, 8'h01);
    rd(ADDR_IRQ_PENDING, got);
    chk_byte(got, 8'h01);
    wr(ADDR_MISC, 8'h00);
    rd(ADDR_DATA, got);
    rd(ADDR_IRQ_PENDING, got);
    chk_byte(got, 8'h00);
    chk_bit(irq_low, 1'b1);
    $display("test mask and clear done");
    results();
  end

  // watchdog well beyond the roughly 1340 cycles the tests need
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    results();
  end
endmodule
